/* File: common/cips_pkg.sv */
// Constants and types shared by the processor priority stack block
package cips_pkg;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int          PRIO_W        = 2;
  localparam int          STACK_W       = 8;
  localparam int          STACK_DEPTH   = STACK_W / PRIO_W;
  localparam logic [1:0]  PRIO_MAX      = 2'h3;
  localparam logic [1:0]  PRIO_NONE     = 2'h0;
  localparam logic [7:0]  STACK_RESET   = 8'hff;
  localparam int          N_SRC_DEFAULT = 8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          MAX_LATENCY_CLK = 20;
  localparam int          MAX_LATENCY_NS  = MAX_LATENCY_CLK * CLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    CIPS_OP_RESTORE = 2'b00,
    CIPS_OP_SET     = 2'b01,
    CIPS_OP_LOAD    = 2'b10,
    CIPS_OP_NONE    = 2'b11
  } cips_op_type;

  typedef struct packed {
    logic              valid;
    cips_op_type       op;
    logic [1:0]        level;
    logic [7:0]        data;
  } cips_cmd_type;

  typedef struct packed {
    logic              req;
    logic [1:0]        level;
  } cips_irq_type;

endpackage

/* File: src/cips_req_select.sv */
// Request selector: picks the winning acceptable interrupt request
`timescale 1ns/1ps
module cips_req_select
  import cips_pkg::*;
#(
  parameter int N_SRC = N_SRC_DEFAULT,
  parameter int SRC_W = (N_SRC > 1) ? $clog2(N_SRC) : 1
) (
  input  wire cips_irq_type [N_SRC-1:0] irq_in,
  input  wire logic [1:0]               cur_prio,
  output logic                          found,
  output logic [SRC_W-1:0]              src,
  output logic [1:0]                    level
);

  // ************************************************************
  // Highest level above current priority, lowest index on ties
  // ************************************************************
  always_comb begin
    found = 1'b0;
    src   = '0;
    level = PRIO_NONE;
    for (int i = 0; i < N_SRC; i++) begin
      if (irq_in[i].req && (irq_in[i].level > cur_prio) &&
          (!found || (irq_in[i].level > level))) begin
        found = 1'b1;
        src   = SRC_W'(i);
        level = irq_in[i].level;
      end
    end
  end

endmodule

/* File: src/cips_prio_stack.sv */
// Processor interrupt priority stack and acceptance logic
`timescale 1ns/1ps
module cips_prio_stack
  import cips_pkg::*;
#(
  parameter int N_SRC = N_SRC_DEFAULT,
  parameter int SRC_W = (N_SRC > 1) ? $clog2(N_SRC) : 1
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  input  wire cips_irq_type [N_SRC-1:0] irq_in,
  input  wire logic                     instr_done,
  input  wire logic                     instr_priv,
  input  wire cips_cmd_type             core_cmd,
  output logic [7:0]                    priority_stack_reg_ff,
  output logic [1:0]                    cur_prio_ff,
  output logic                          irq_take_ff,
  output logic [SRC_W-1:0]              irq_src_ff,
  output logic [1:0]                    irq_level_ff,
  output logic                          irq_held_ff
);

  // ************************************************************
  // Selection
  // ************************************************************
  logic             sel_found;
  logic [SRC_W-1:0] sel_src;
  logic [1:0]       sel_level;
  logic             any_req;
  logic             accept_c;

  cips_req_select #(
    .N_SRC (N_SRC),
    .SRC_W (SRC_W)
  ) u_select (
    .irq_in   (irq_in),
    .cur_prio (priority_stack_reg_ff[PRIO_W-1:0]),
    .found    (sel_found),
    .src      (sel_src),
    .level    (sel_level)
  );

  always_comb begin
    any_req = 1'b0;
    for (int i = 0; i < N_SRC; i++) begin
      any_req = any_req | irq_in[i].req;
    end
  end

  // Taken only at the end of an unprivileged instruction with no stack op in flight
  assign accept_c = sel_found && instr_done && !instr_priv && !core_cmd.valid;

  // ************************************************************
  // Next state
  // ************************************************************
  logic [7:0]       nxt_stack;
  logic [1:0]       nxt_cur;
  logic             nxt_take;
  logic [SRC_W-1:0] nxt_src;
  logic [1:0]       nxt_level;
  logic             nxt_held;

  always_comb begin
    nxt_stack = priority_stack_reg_ff;
    nxt_take  = 1'b0;
    nxt_src   = irq_src_ff;
    nxt_level = irq_level_ff;
    if (core_cmd.valid) begin
      case (core_cmd.op)
        CIPS_OP_RESTORE: begin
          // Top entry is kept so the stack never invents a lower priority
          nxt_stack = {priority_stack_reg_ff[STACK_W-1 -: PRIO_W],
                       priority_stack_reg_ff[STACK_W-1:PRIO_W]};
        end
        CIPS_OP_SET: begin
          nxt_stack = {priority_stack_reg_ff[STACK_W-PRIO_W-1:0], core_cmd.level};
        end
        CIPS_OP_LOAD: begin
          nxt_stack = core_cmd.data;
        end
        default: begin
          nxt_stack = priority_stack_reg_ff;
        end
      endcase
    end else if (accept_c) begin
      nxt_stack = {priority_stack_reg_ff[STACK_W-PRIO_W-1:0], sel_level};
      nxt_take  = 1'b1;
      nxt_src   = sel_src;
      nxt_level = sel_level;
    end
    nxt_cur  = nxt_stack[PRIO_W-1:0];
    nxt_held = any_req && !nxt_take;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      priority_stack_reg_ff <= STACK_RESET;
      cur_prio_ff           <= STACK_RESET[PRIO_W-1:0];
      irq_take_ff           <= 1'b0;
      irq_src_ff            <= '0;
      irq_level_ff          <= PRIO_NONE;
      irq_held_ff           <= 1'b0;
    end else if (clk_en) begin
      priority_stack_reg_ff <= nxt_stack;
      cur_prio_ff           <= nxt_cur;
      irq_take_ff           <= nxt_take;
      irq_src_ff            <= nxt_src;
      irq_level_ff          <= nxt_level;
      irq_held_ff           <= nxt_held;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic better_c;

  always_comb begin
    better_c = 1'b0;
    for (int i = 0; i < N_SRC; i++) begin
      if (irq_in[i].req && (irq_in[i].level > priority_stack_reg_ff[PRIO_W-1:0])) begin
        if ((irq_in[i].level > sel_level) ||
            ((irq_in[i].level == sel_level) && (SRC_W'(i) < sel_src))) begin
          better_c = 1'b1;
        end
      end
    end
  end

  property p_cur_matches_stack;
    @(posedge sys_clk) disable iff (sys_rst)
      cur_prio_ff == priority_stack_reg_ff[PRIO_W-1:0];
  endproperty
  a_cur_matches_stack: assert property (p_cur_matches_stack)
    else $error("current priority differs from stack bits 1:0");

  property p_push_on_accept;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && accept_c) |=>
        (priority_stack_reg_ff == {$past(priority_stack_reg_ff[5:0]), $past(sel_level)})
        && irq_take_ff && (irq_src_ff == $past(sel_src));
  endproperty
  a_push_on_accept: assert property (p_push_on_accept)
    else $error("accepted interrupt did not push its level");

  property p_depth_kept;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && core_cmd.valid && core_cmd.op == CIPS_OP_SET) ##1
      (clk_en && core_cmd.valid && core_cmd.op == CIPS_OP_RESTORE) |=>
        priority_stack_reg_ff[STACK_W-PRIO_W-1:0] ==
          $past(priority_stack_reg_ff[STACK_W-PRIO_W-1:0], 2);
  endproperty
  a_depth_kept: assert property (p_depth_kept)
    else $error("set then restore lost saved entries");

  property p_restore;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && core_cmd.valid && core_cmd.op == CIPS_OP_RESTORE) |=>
        (priority_stack_reg_ff[5:0] == $past(priority_stack_reg_ff[7:2])) && !irq_take_ff;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore did not shift stack right by two");

  property p_set;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && core_cmd.valid && core_cmd.op == CIPS_OP_SET) |=>
        (cur_prio_ff == $past(core_cmd.level)) &&
        (priority_stack_reg_ff[7:2] == $past(priority_stack_reg_ff[5:0]));
  endproperty
  a_set: assert property (p_set)
    else $error("set did not push its level");

  property p_load;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && core_cmd.valid && core_cmd.op == CIPS_OP_LOAD) |=>
        priority_stack_reg_ff == $past(core_cmd.data);
  endproperty
  a_load: assert property (p_load)
    else $error("stack reload from memory failed");

  property p_level_above;
    @(posedge sys_clk) disable iff (sys_rst)
      ($rose(irq_take_ff) || (irq_take_ff && $past(clk_en))) |->
        (irq_level_ff > priority_stack_reg_ff[3:2]) && (cur_prio_ff == irq_level_ff);
  endproperty
  a_level_above: assert property (p_level_above)
    else $error("accepted level not above previous priority");

  property p_suppress_at_max;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && cur_prio_ff == PRIO_MAX) |=> !irq_take_ff;
  endproperty
  a_suppress_at_max: assert property (p_suppress_at_max)
    else $error("interrupt accepted at priority 3");

  property p_defer_priv;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && (!instr_done || instr_priv)) |=> !irq_take_ff;
  endproperty
  a_defer_priv: assert property (p_defer_priv)
    else $error("interrupt accepted outside an unprivileged boundary");

  property p_take_when_eligible;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && sel_found && instr_done && !instr_priv && !core_cmd.valid) |=> irq_take_ff;
  endproperty
  a_take_when_eligible: assert property (p_take_when_eligible)
    else $error("eligible request not accepted at boundary");

  property p_best_pick;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && accept_c) |-> !better_c;
  endproperty
  a_best_pick: assert property (p_best_pick)
    else $error("winner is not highest level lowest source");

endmodule

/* File: dv/cips_periph_model.sv */
// Peripheral side model: each request stays up until its own take or its drop is seen
`timescale 1ns/1ps
module cips_periph_model
  import cips_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire logic [N-1:0]    raise,
  input  wire logic [N-1:0]    drop,
  input  wire logic [2*N-1:0]  cfg_level,
  input  wire logic            irq_take,
  input  wire logic [1:0]      irq_src,
  output cips_irq_type [N-1:0] irq_out
);
  logic [N-1:0] pend_ff;

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < N; i++) begin
      if (sys_rst || drop[i] || (irq_take && irq_src == i)) begin
        pend_ff[i] <= 1'b0;
      end else if (raise[i]) begin
        pend_ff[i] <= 1'b1;
      end
    end
  end

  // Level comes from the peripheral's own control field
  always_comb begin
    for (int i = 0; i < N; i++) begin
      irq_out[i].req   = pend_ff[i];
      irq_out[i].level = cfg_level[2*i +: 2];
    end
  end
endmodule

/* File: dv/tb_cips_prio_stack.sv */
// Testbench for the processor priority stack block
`timescale 1ns/1ps
module tb_cips_prio_stack;
  import cips_pkg::*;
  logic               sys_clk, sys_rst, clk_en, instr_done, instr_priv;
  logic               irq_take_ff, irq_held_ff;
  logic [3:0]         raise, drop;
  logic [7:0]         cfg, priority_stack_reg_ff;
  logic [1:0]         cur_prio_ff, irq_src_ff, irq_level_ff;
  cips_irq_type [3:0] irq_in;
  cips_cmd_type       core_cmd;
  int                 num_errors, num_checks;

  cips_prio_stack #(.N_SRC(4)) cips_prio_stack_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .irq_in(irq_in), .instr_done(instr_done), .instr_priv(instr_priv),
    .core_cmd(core_cmd), .priority_stack_reg_ff(priority_stack_reg_ff),
    .cur_prio_ff(cur_prio_ff), .irq_take_ff(irq_take_ff), .irq_src_ff(irq_src_ff),
    .irq_level_ff(irq_level_ff), .irq_held_ff(irq_held_ff));
  cips_periph_model #(.N(4)) cips_periph_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .raise(raise), .drop(drop), .cfg_level(cfg), .irq_take(irq_take_ff),
    .irq_src(irq_src_ff), .irq_out(irq_in));

  // ************
  // Helpers
  // ************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic do_op(input cips_op_type o, input logic [1:0] l, input logic [7:0] d);
    core_cmd = '{1'b1, o, l, d};
    step();
    core_cmd.valid = 1'b0;
    step();
  endtask
  task automatic req(input logic [3:0] r);
    raise = r;
    step();
    raise = 4'h0;
  endtask
  task automatic bnd(input logic p, output logic tk);
    instr_done = 1'b1;
    instr_priv = p;
    step();
    instr_done = 1'b0;
    instr_priv = 1'b0;
    tk = irq_take_ff;
    step();
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ************
  // Scenarios
  // ************
  task automatic t_ops();
    logic [7:0] s;
    chk("rst", priority_stack_reg_ff, 8'hff);
    do_op(CIPS_OP_LOAD, 2'h0, 8'h1b);
    chk("load", priority_stack_reg_ff, 8'h1b);
    s = 8'h1b;
    for (int l = 0; l < 4; l++) begin
      do_op(CIPS_OP_SET, 2'(l), 8'h00);
      s = {s[5:0], 2'(l)};
      chk("set", priority_stack_reg_ff, s);
      chk("cur", {6'h0, cur_prio_ff}, {6'h0, s[1:0]});
    end
    core_cmd = '{1'b1, CIPS_OP_SET, 2'h2, 8'h00};
    step();
    core_cmd = '{1'b1, CIPS_OP_RESTORE, 2'h0, 8'h00};
    step();
    core_cmd.valid = 1'b0;
    step();
    s = {s[5:4], s[5:0]};
    chk("set_restore", priority_stack_reg_ff, s);
    for (int k = 0; k < 4; k++) begin
      do_op(CIPS_OP_RESTORE, 2'h0, 8'h00);
      s = {s[7:6], s[7:2]};
      chk("restore", priority_stack_reg_ff, s);
    end
    clk_en = 1'b0;
    core_cmd = '{1'b1, CIPS_OP_LOAD, 2'h0, 8'h5a};
    step();
    chk("freeze", priority_stack_reg_ff, s);
    core_cmd.valid = 1'b0;
    step();
    clk_en = 1'b1;
  endtask
  task automatic t_accept();
    logic tk;
    logic [7:0] s;
    for (int c = 0; c < 4; c++) for (int l = 1; l < 4; l++) begin
      s = 8'hc4 | 8'(c);
      do_op(CIPS_OP_LOAD, 2'h0, s);
      chk("idle", {7'h0, irq_held_ff}, 8'h00);
      cfg[3:2] = 2'(l);
      req(4'h2);
      bnd(1'b0, tk);
      chk("take", {7'h0, tk}, {7'h0, l > c});
      chk("stack", priority_stack_reg_ff, (l > c) ? {s[5:0], 2'(l)} : s);
      if (l > c) chk("lvl", {6'h0, irq_level_ff}, 8'(l));
      else chk("held", {7'h0, irq_held_ff}, 8'h01);
      drop = 4'h2;
      step();
      drop = 4'h0;
    end
  endtask
  task automatic t_tie();
    logic tk;
    logic [1:0] want [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    do_op(CIPS_OP_LOAD, 2'h0, 8'h00);
    cfg = 8'he9;
    req(4'hf);
    for (int k = 0; k < 4; k++) begin
      bnd(1'b0, tk);
      chk("tie", {6'h0, irq_src_ff}, {6'h0, want[k]});
      do_op(CIPS_OP_RESTORE, 2'h0, 8'h00);
    end
  endtask
  task automatic t_defer();
    logic tk;
    cfg = 8'h02;
    req(4'h1);
    bnd(1'b1, tk);
    chk("priv", {7'h0, tk}, 8'h00);
    bnd(1'b0, tk);
    chk("unpriv", {7'h0, tk}, 8'h01);
    do_op(CIPS_OP_RESTORE, 2'h0, 8'h00);
    req(4'h1);
    instr_done = 1'b1;
    core_cmd = '{1'b1, CIPS_OP_SET, 2'h1, 8'h00};
    step();
    instr_done = 1'b0;
    core_cmd.valid = 1'b0;
    chk("collide", {7'h0, irq_take_ff}, 8'h00);
    step();
    bnd(1'b0, tk);
    chk("retry", priority_stack_reg_ff, 8'h06);
  endtask

  task automatic t_reset();
    logic tk;
    clk_en = 1'b0;
    sys_rst = 1'b1;
    step();
    sys_rst = 1'b0;
    clk_en = 1'b1;
    chk("rst_stack", priority_stack_reg_ff, STACK_RESET);
    chk("rst_cur", {6'h0, cur_prio_ff}, {6'h0, PRIO_MAX});
    chk("rst_out", {2'h0, irq_take_ff, irq_held_ff, irq_level_ff, irq_src_ff}, 8'h00);
    cfg = 8'h02;
    req(4'h1);
    bnd(1'b0, tk);
    chk("rst_block", {7'h0, tk}, 8'h00);
    drop = 4'h1;
    step();
    drop = 4'h0;
  endtask

  initial begin
    num_errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    instr_done = 1'b0;
    instr_priv = 1'b0;
    raise = 4'h0;
    drop = 4'h0;
    cfg = 8'h00;
    core_cmd = '{1'b0, CIPS_OP_NONE, 2'h0, 8'h00};
    step();
    step();
    sys_rst = 1'b0;
    t_ops();
    t_accept();
    t_tie();
    t_defer();
    t_reset();
    wrap_up();
  end
endmodule
